//--- design/dss_debounce.sv
// module: input debouncer with a stable-time window
module dss_debounce #(
    parameter int unsigned WINDOW = dss_pkg::DEB_CYCLES_DEF
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);

    logic [dss_pkg::CNT_W-1:0] cnt_reg;
    logic [dss_pkg::CNT_W-1:0] cnt_next;
    logic                      out_reg;
    logic                      out_next;

    always_comb begin
        cnt_next = '0;
        out_next = out_reg;
        if (din != out_reg) begin
            if (cnt_reg >= dss_pkg::CNT_W'(WINDOW - 1)) begin
                out_next = din;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
            out_reg <= dss_pkg::MR_DEB_RESET;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;

endmodule : dss_debounce

//--- design/dss_pkg.sv
// package: timing constants and reset values for the supply supervisor
package dss_pkg;

    // clock period
    localparam int unsigned CLK_PERIOD_PS   = 4000;
    // watchdog pulse length
    localparam int unsigned WD_PULSE_MS     = 150;
    localparam int unsigned WD_PULSE_CYCLES =
        32'((64'(WD_PULSE_MS) * 64'h3B9ACA00) / 64'(CLK_PERIOD_PS));
    // default reset hold and debounce windows, in clock cycles
    localparam int unsigned HOLD_CYCLES_DEF = 50000000;
    localparam int unsigned DEB_CYCLES_DEF  = 2500000;
    // counter width
    localparam int unsigned CNT_W           = 32;
    // supply selection encodings
    localparam logic        SEL_PRIMARY     = 1'b0;
    localparam logic        SEL_BATTERY     = 1'b1;
    // output levels after reset
    localparam logic        RST_OUT_RESET   = 1'b0;
    localparam logic        WDO_RESET       = 1'b1;
    localparam logic        MR_DEB_RESET    = 1'b1;

    typedef enum logic [1:0] {
        DSS_HOLD    = 2'b00,
        DSS_RUN     = 2'b01,
        DSS_ASSERT  = 2'b10
    } dss_rst_e;

endpackage : dss_pkg

//--- design/dss_supervisor.sv
// module: dual supply supervisor outputs
// How it works
// - fail output low while second supply low
// - fail output follows comparator, no delay
// - reset asserted while primary below sense level
// - hold reset after recovery, restart on drop
// - power-up reset held for hold time
// - bus traffic ignored while reset asserted
// - debounced manual reset asserts reset
// - hold reset after manual reset release
// - watchdog output low for 150ms per timeout
// - supply select with hysteresis around battery
// - bus data sampled on MCLK
// - state kept while running from battery
// - backup-active high when battery selected
// - primary-low output follows comparator immediately
module dss_supervisor #(
    parameter int unsigned HOLD_CYCLES = dss_pkg::HOLD_CYCLES_DEF,
    parameter int unsigned DEB_CYCLES  = dss_pkg::DEB_CYCLES_DEF,
    parameter int unsigned WD_CYCLES   = dss_pkg::WD_PULSE_CYCLES
) (
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic PRIMARY_ABOVE_TRIP,
    input  wire logic SECOND_ABOVE_TRIP,
    input  wire logic PRIMARY_ABOVE_BATT_HI,
    input  wire logic PRIMARY_BELOW_BATT_LO,
    input  wire logic MANUAL_RESET_IN_N,
    input  wire logic WATCHDOG_TIMEOUT,
    input  wire logic SCL_IN,
    input  wire logic SDA_IN,
    output logic      RESET_OUT_N,
    output logic      RESET_OE_N,
    output logic      SECOND_SUPPLY_FAIL_OUT_N,
    output logic      PRIMARY_LOW_OUT_N,
    output logic      WATCHDOG_OUT_N,
    output logic      BACKUP_ACTIVE_OUT,
    output logic      BUS_ENABLE,
    output logic      BUS_SCL,
    output logic      BUS_SDA
);

    ////////////////////////////////////////////////////////////////////////
    // span counter helpers

    // last cycle of a span of n cycles reached
    function automatic logic span_done(
        input logic [dss_pkg::CNT_W-1:0] cnt,
        input int unsigned               n
    );
        return cnt >= dss_pkg::CNT_W'(n - 1);
    endfunction : span_done

    function automatic logic [dss_pkg::CNT_W-1:0] span_step(
        input logic [dss_pkg::CNT_W-1:0] cnt
    );
        return cnt + 1'b1;
    endfunction : span_step

    ////////////////////////////////////////////////////////////////////////
    // manual reset debounce

    logic                      mr_deb_n;

    dss_debounce #(
        .WINDOW (DEB_CYCLES)
    ) u_mr_deb (
        .clk    (MCLK),
        .rst    (RST),
        .din    (MANUAL_RESET_IN_N),
        .dout   (mr_deb_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer

    dss_pkg::dss_rst_e         rst_st_reg;
    dss_pkg::dss_rst_e         rst_st_next;
    logic [dss_pkg::CNT_W-1:0] hold_cnt_reg;
    logic [dss_pkg::CNT_W-1:0] hold_cnt_next;
    logic                      rst_out_reg;
    logic                      rst_out_next;
    logic                      reset_cause;

    assign reset_cause = !PRIMARY_ABOVE_TRIP || !mr_deb_n;

    always_comb begin
        rst_st_next   = rst_st_reg;
        hold_cnt_next = hold_cnt_reg;
        rst_out_next  = rst_out_reg;
        unique case (rst_st_reg)
            dss_pkg::DSS_ASSERT: begin
                rst_out_next  = 1'b0;
                hold_cnt_next = '0;
                if (!reset_cause) begin
                    rst_st_next = dss_pkg::DSS_HOLD;
                end
            end
            dss_pkg::DSS_HOLD: begin
                rst_out_next = 1'b0;
                if (reset_cause) begin
                    rst_st_next   = dss_pkg::DSS_ASSERT;
                    hold_cnt_next = '0;
                end else if (span_done(hold_cnt_reg, HOLD_CYCLES)) begin
                    rst_st_next  = dss_pkg::DSS_RUN;
                    rst_out_next = 1'b1;
                end else begin
                    hold_cnt_next = span_step(hold_cnt_reg);
                end
            end
            dss_pkg::DSS_RUN: begin
                rst_out_next = 1'b1;
                if (reset_cause) begin
                    rst_st_next  = dss_pkg::DSS_ASSERT;
                    rst_out_next = 1'b0;
                end
            end
            default: begin
                rst_st_next   = dss_pkg::DSS_ASSERT;
                rst_out_next  = 1'b0;
                hold_cnt_next = '0;
            end
        endcase
    end

    // state is never cleared by supply selection, only by RST
    always_ff @(posedge MCLK) begin
        if (RST) begin
            rst_st_reg   <= dss_pkg::DSS_HOLD;
            hold_cnt_reg <= '0;
            rst_out_reg  <= dss_pkg::RST_OUT_RESET;
        end else begin
            rst_st_reg   <= rst_st_next;
            hold_cnt_reg <= hold_cnt_next;
            rst_out_reg  <= rst_out_next;
        end
    end

    assign RESET_OUT_N = 1'b0;
    assign RESET_OE_N  = rst_out_reg;              // open drain: low drives

    ////////////////////////////////////////////////////////////////////////
    // watchdog pulse

    logic [dss_pkg::CNT_W-1:0] wd_cnt_reg;
    logic [dss_pkg::CNT_W-1:0] wd_cnt_next;
    logic                      wdo_reg;
    logic                      wdo_next;

    always_comb begin
        wd_cnt_next = wd_cnt_reg;
        wdo_next    = wdo_reg;
        if (!wdo_reg) begin
            if (span_done(wd_cnt_reg, WD_CYCLES)) begin
                wdo_next    = 1'b1;
                wd_cnt_next = '0;
            end else begin
                wd_cnt_next = span_step(wd_cnt_reg);
            end
        end else if (WATCHDOG_TIMEOUT) begin
            wdo_next    = 1'b0;
            wd_cnt_next = '0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wd_cnt_reg <= '0;
            wdo_reg    <= dss_pkg::WDO_RESET;
        end else begin
            wd_cnt_reg <= wd_cnt_next;
            wdo_reg    <= wdo_next;
        end
    end

    assign WATCHDOG_OUT_N = wdo_reg;

    ////////////////////////////////////////////////////////////////////////
    // supply selection

    logic                      sel_reg;
    logic                      sel_next;

    always_comb begin
        sel_next = sel_reg;
        if (PRIMARY_ABOVE_TRIP) begin
            sel_next = dss_pkg::SEL_PRIMARY;
        end else if (PRIMARY_ABOVE_BATT_HI) begin
            sel_next = dss_pkg::SEL_PRIMARY;
        end else if (PRIMARY_BELOW_BATT_LO) begin
            sel_next = dss_pkg::SEL_BATTERY;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            sel_reg <= dss_pkg::SEL_PRIMARY;
        end else begin
            sel_reg <= sel_next;
        end
    end

    assign BACKUP_ACTIVE_OUT = (sel_reg == dss_pkg::SEL_BATTERY);

    ////////////////////////////////////////////////////////////////////////
    // direct comparator outputs

    assign SECOND_SUPPLY_FAIL_OUT_N = SECOND_ABOVE_TRIP;
    assign PRIMARY_LOW_OUT_N        = PRIMARY_ABOVE_TRIP;

    ////////////////////////////////////////////////////////////////////////
    // bus gating

    logic                      bus_en_reg;
    logic                      bus_en_next;
    logic                      bus_scl_reg;
    logic                      bus_scl_next;
    logic                      bus_sda_reg;
    logic                      bus_sda_next;

    // idle bus levels force the engine to abort and ignore traffic
    always_comb begin
        bus_en_next  = rst_out_next;
        bus_scl_next = 1'b1;
        bus_sda_next = 1'b1;
        if (rst_out_next) begin
            bus_scl_next = SCL_IN;
            bus_sda_next = SDA_IN;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            bus_en_reg  <= 1'b0;
            bus_scl_reg <= 1'b1;
            bus_sda_reg <= 1'b1;
        end else begin
            bus_en_reg  <= bus_en_next;
            bus_scl_reg <= bus_scl_next;
            bus_sda_reg <= bus_sda_next;
        end
    end

    assign BUS_ENABLE = bus_en_reg;
    assign BUS_SCL    = bus_scl_reg;
    assign BUS_SDA    = bus_sda_reg;

endmodule : dss_supervisor

//--- verif/dss_host_model.sv
// host model: sees the open-drain reset wire with its pull-up
module dss_host_model (
    input  wire logic reset_out_n,
    input  wire logic reset_oe_n,
    output logic      reset_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pin floats to the pull-up
    assign reset_line = reset_oe_n ? 1'b1 : reset_out_n;
endmodule : dss_host_model

//--- verif/dss_supervisor_bench.sv
// testbench: directed scenarios for the supply supervisor
module dss_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HOLD = 20;
    localparam int unsigned DEB  = 4;
    localparam int unsigned WD   = 30;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic PRIMARY_ABOVE_TRIP = 1'b1;
    logic SECOND_ABOVE_TRIP = 1'b1;
    logic PRIMARY_ABOVE_BATT_HI = 1'b1;
    logic PRIMARY_BELOW_BATT_LO = 1'b0;
    logic MANUAL_RESET_IN_N = 1'b1;
    logic WATCHDOG_TIMEOUT = 1'b0;
    logic SCL_IN = 1'b1;
    logic SDA_IN = 1'b1;
    logic RESET_OUT_N, RESET_OE_N, SECOND_SUPPLY_FAIL_OUT_N;
    logic PRIMARY_LOW_OUT_N, WATCHDOG_OUT_N, BACKUP_ACTIVE_OUT;
    logic BUS_ENABLE, BUS_SCL, BUS_SDA, reset_line;
    int n_errors = 0;
    int check_count = 0;
    always #2 MCLK = ~MCLK;
    dss_supervisor #(.HOLD_CYCLES(HOLD), .DEB_CYCLES(DEB), .WD_CYCLES(WD))
        u_dss_supervisor (.*);
    dss_host_model u_dss_host_model (.reset_out_n(RESET_OUT_N),
        .reset_oe_n(RESET_OE_N), .reset_line(reset_line));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic ok);
        check_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: output mismatch", $time);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge MCLK);
    endtask : tick
    // cycles until the reset wire is released
    task automatic wait_rel(output int n);
        n = 0;
        while (reset_line !== 1'b1 && n < 500) begin
            tick(1);
            n++;
        end
    endtask : wait_rel
    ////////////////////////////////////////////////////////////////////////
    task automatic t_primary();
        int n;
        PRIMARY_ABOVE_TRIP = 1'b0;
        SECOND_ABOVE_TRIP = 1'b0;
        SCL_IN = 1'b0;
        SDA_IN = 1'b0;
        #1 chk(!PRIMARY_LOW_OUT_N && !SECOND_SUPPLY_FAIL_OUT_N);
        tick(2);
        chk(!reset_line && !BUS_ENABLE && BUS_SCL && BUS_SDA);
        PRIMARY_ABOVE_TRIP = 1'b1;
        SECOND_ABOVE_TRIP = 1'b1;
        #1 chk(PRIMARY_LOW_OUT_N && SECOND_SUPPLY_FAIL_OUT_N);
        tick(HOLD / 2);
        chk(!reset_line);
        PRIMARY_ABOVE_TRIP = 1'b0;
        tick(1);
        PRIMARY_ABOVE_TRIP = 1'b1;
        wait_rel(n);
        chk(n >= HOLD + 1 && n <= HOLD + 2);
        tick(1);
        chk(BUS_SCL === 1'b0 && BUS_SDA === 1'b0);
        SCL_IN = 1'b1;
        SDA_IN = 1'b0;
        tick(1);
        chk(BUS_SCL === 1'b1 && BUS_SDA === 1'b0);
        SDA_IN = 1'b1;
    endtask : t_primary
    task automatic t_manual();
        int n;
        MANUAL_RESET_IN_N = 1'b0;
        tick(DEB - 2);
        MANUAL_RESET_IN_N = 1'b1;
        tick(3);
        chk(reset_line);
        MANUAL_RESET_IN_N = 1'b0;
        tick(DEB + 8);
        chk(!reset_line);
        MANUAL_RESET_IN_N = 1'b1;
        wait_rel(n);
        chk(n >= DEB + HOLD && n <= DEB + HOLD + 3);
    endtask : t_manual
    task automatic t_watchdog();
        int n = 0;
        WATCHDOG_TIMEOUT = 1'b1;
        for (int i = 0; i < WD + 10; i++) begin
            tick(1);
            WATCHDOG_TIMEOUT = (i == 10);
            n += (WATCHDOG_OUT_N === 1'b0);
        end
        chk(n == WD);
    endtask : t_watchdog
    task automatic t_select();
        int n;
        logic [3:0] tbl [7] = '{4'hA, 4'h3, 4'h1, 4'h4, 4'h0, 4'h3, 4'h8};
        foreach (tbl[i]) begin
            {PRIMARY_ABOVE_TRIP, PRIMARY_ABOVE_BATT_HI} = tbl[i][3:2];
            PRIMARY_BELOW_BATT_LO = tbl[i][1];
            tick(1);
            chk(BACKUP_ACTIVE_OUT === tbl[i][0]);
        end
        wait_rel(n);
        chk(n == HOLD);
    endtask : t_select
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        tick(4);
        RST = 1'b0;
        wait_rel(n);
        chk(n >= HOLD && n <= HOLD + 1 && BUS_ENABLE);
        t_primary();
        t_manual();
        t_watchdog();
        t_select();
        conclude();
    end
    initial begin
        #20000;
        n_errors++;
        conclude();
    end
endmodule : dss_supervisor_bench

bind dss_supervisor dss_supervisor_monitor #(.HOLD_CYCLES(HOLD_CYCLES),
    .WD_CYCLES(WD_CYCLES)) u_dss_supervisor_monitor (.*);

//--- verif/dss_supervisor_monitor.sv
// checker: port properties of the supply supervisor
module dss_supervisor_monitor #(
    parameter int unsigned HOLD_CYCLES = 20,
    parameter int unsigned WD_CYCLES   = 30
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PRIMARY_ABOVE_TRIP,
    input wire logic SECOND_ABOVE_TRIP,
    input wire logic PRIMARY_ABOVE_BATT_HI,
    input wire logic PRIMARY_BELOW_BATT_LO,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic RESET_OE_N,
    input wire logic SECOND_SUPPLY_FAIL_OUT_N,
    input wire logic PRIMARY_LOW_OUT_N,
    input wire logic WATCHDOG_OUT_N,
    input wire logic BACKUP_ACTIVE_OUT,
    input wire logic BUS_ENABLE,
    input wire logic BUS_SCL,
    input wire logic BUS_SDA
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned good_cnt;
    int unsigned wd_cnt;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    // good supply run length and watchdog pulse length
    always_ff @(posedge MCLK) begin
        good_cnt <= (RST || !PRIMARY_ABOVE_TRIP) ? 0 : good_cnt + 1;
        wd_cnt   <= (RST || WATCHDOG_OUT_N) ? 0 : wd_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_FAIL: assert property (
        SECOND_SUPPLY_FAIL_OUT_N == SECOND_ABOVE_TRIP) else $error("fail");
    AST_LOWLINE: assert property (
        PRIMARY_LOW_OUT_N == PRIMARY_ABOVE_TRIP) else $error("low flag");
    AST_RST_ON: assert property (
        !PRIMARY_ABOVE_TRIP |=> !RESET_OE_N) else $error("reset late");
    AST_RST_HOLD: assert property (
        $rose(RESET_OE_N) |-> good_cnt >= HOLD_CYCLES) else $error("hold");
    AST_BUS_OFF: assert property (
        !RESET_OE_N |-> !BUS_ENABLE) else $error("bus open");
    AST_BUS_COPY: assert property (
        BUS_ENABLE && $past(BUS_ENABLE) |-> BUS_SCL == $past(SCL_IN)
        && BUS_SDA == $past(SDA_IN)) else $error("bus copy");
    AST_WDO_GO: assert property (
        WATCHDOG_TIMEOUT && WATCHDOG_OUT_N |=> !WATCHDOG_OUT_N)
        else $error("wdo late");
    AST_WDO_LEN: assert property (
        $rose(WATCHDOG_OUT_N) && !$past(RST) |-> wd_cnt == WD_CYCLES)
        else $error("wdo length");
    AST_SEL_PRI: assert property (
        PRIMARY_ABOVE_TRIP || PRIMARY_ABOVE_BATT_HI |=> !BACKUP_ACTIVE_OUT)
        else $error("select primary");
    AST_SEL_BAT: assert property (
        !PRIMARY_ABOVE_TRIP && !PRIMARY_ABOVE_BATT_HI && PRIMARY_BELOW_BATT_LO
        |=> BACKUP_ACTIVE_OUT) else $error("select battery");
    COV_REL: cover property ($rose(RESET_OE_N));
    COV_WDO: cover property ($rose(WATCHDOG_OUT_N));
    COV_BAT: cover property ($rose(BACKUP_ACTIVE_OUT));
endmodule : dss_supervisor_monitor
